// ### swd_checker.sv
`timescale 1ns/10ps
module swd_checker #(
    parameter NUM_SP = 16, // setpoints
    parameter IDX_W  = 4   // index width
) (
    input wire              clk_sys,              // clock
    input wire              rstn,                 // reset, low
    input wire              acq_armed,            // armed
    input wire              scan_valid,           // word strobe
    input wire              scan_sp_en,           // has setpoint
    input wire [IDX_W-1:0]  scan_sp_idx,          // setpoint
    input wire              scan_stat_slot,       // status slot
    input wire [NUM_SP-1:0] setpoint_state_flags, // flags
    input wire [NUM_SP-1:0] channel_match_flag,   // marks
    input wire              stat_valid,           // status out
    input wire [15:0]       stat_word,            // status data
    input wire [15:0]       analog_out_zero,      // dac 0
    input wire [15:0]       pulse_output_zero,    // timer 0
    input wire [3:0]        out_upd_stb           // strobes
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // an evaluation and a status slot, each one stream word
    sequence eval_s;
        scan_valid && scan_sp_en && acq_armed;
    endsequence
    sequence stat_s;
        scan_valid && scan_stat_slot;
    endsequence
    flag_hold_a: assert property (
        !(scan_valid && scan_sp_en && acq_armed)
        |=> $stable(setpoint_state_flags)) else $error("flags moved");
    one_bit_a: assert property (eval_s |=> ((setpoint_state_flags
        ^ $past(setpoint_state_flags)) & ~(NUM_SP'(1) << $past(scan_sp_idx)))
        == 0) else $error("other setpoint flag moved");
    mark_copy_a: assert property (
        eval_s |=> channel_match_flag == setpoint_state_flags)
        else $error("match flag differs");
    stat_out_a: assert property (stat_s |=> stat_valid)
        else $error("status word missing");
    stat_only_a: assert property (stat_valid |-> $past(scan_valid
        && scan_stat_slot)) else $error("stray status word");
    stat_data_a: assert property (
        stat_s |=> stat_word == $past(setpoint_state_flags))
        else $error("status word wrong");
    stat_keep_a: assert property (!(scan_valid && scan_stat_slot)
        |=> $stable(stat_word)) else $error("status word moved");
    dac_hold_a: assert property (
        !out_upd_stb[0] |-> $stable(analog_out_zero)) else $error("dac moved");
    tmr_hold_a: assert property (
        !out_upd_stb[2] |-> $stable(pulse_output_zero)) else $error("tmr moved");
    stb_cause_a: assert property ((|out_upd_stb) |-> $past(scan_valid
        && scan_sp_en && acq_armed)) else $error("strobe without eval");
endmodule
bind swd_setpoint_window_detector swd_checker #(.NUM_SP(NUM_SP),
    .IDX_W(IDX_W)) chk_i (.clk_sys(clk_sys), .rstn(rstn),
    .acq_armed(acq_armed), .scan_valid(scan_valid), .scan_sp_en(scan_sp_en),
    .scan_sp_idx(scan_sp_idx), .scan_stat_slot(scan_stat_slot),
    .setpoint_state_flags(setpoint_state_flags),
    .channel_match_flag(channel_match_flag), .stat_valid(stat_valid),
    .stat_word(stat_word), .analog_out_zero(analog_out_zero),
    .pulse_output_zero(pulse_output_zero), .out_upd_stb(out_upd_stb));

// ### swd_defines.vh
`ifndef SWD_DEFINES_VH
`define SWD_DEFINES_VH

// ************************************************************
// setup write port field selects
// ************************************************************
`define SWD_FLD_HIGH      3'h0
`define SWD_FLD_LOW       3'h1
`define SWD_FLD_MODE      3'h2
`define SWD_FLD_VAL_TRUE  3'h3
`define SWD_FLD_VAL_FALSE 3'h4

// ************************************************************
// mode word layout
// ************************************************************
`define SWD_MODE_CRIT_LSB 0
`define SWD_MODE_CRIT_MSB 2
`define SWD_MODE_TGT_LSB  3
`define SWD_MODE_TGT_MSB  5
`define SWD_MODE_TF_BIT   6
`define SWD_MODE_W        7

// ************************************************************
// criterion codes
// ************************************************************
`define SWD_CRIT_INSIDE   3'h0
`define SWD_CRIT_OUTSIDE  3'h1
`define SWD_CRIT_GREATER  3'h2
`define SWD_CRIT_LESS     3'h3
`define SWD_CRIT_EQUAL    3'h4
`define SWD_CRIT_HYST     3'h5

// ************************************************************
// output target codes
// ************************************************************
`define SWD_TGT_NONE      3'h0
`define SWD_TGT_ANALOG_OUT_ZERO      3'h1
`define SWD_TGT_ANALOG_OUT_ONE      3'h2
`define SWD_TGT_TMR0      3'h3
`define SWD_TGT_TMR1      3'h4

// ************************************************************
// reset values
// ************************************************************
`define SWD_RST_WORD      16'h0000
`define SWD_RST_MODE      7'h00

`endif

// ### swd_scan_seq.sv
`timescale 1ns/10ps
module swd_scan_seq (
    input  wire        clk_sys,       // clock
    output reg         scan_valid,    // word strobe
    output reg  [15:0] scan_word,     // channel word
    output reg         scan_sp_en,    // has setpoint
    output reg  [3:0]  scan_sp_idx,   // setpoint
    output reg         scan_stat_slot // status slot
);
    // quiet stream at time zero
    initial begin
        {scan_valid, scan_sp_en, scan_stat_slot} = 3'h0;
        scan_word = 16'h0000;
        scan_sp_idx = 4'h0;
    end
    // one word per cycle; status slot comes last in a scan
    task put(input s, input [3:0] i, input [15:0] w, input t);
        @(posedge clk_sys);
        #1;
        {scan_valid, scan_sp_en, scan_stat_slot} = {1'b1, s, t};
        scan_sp_idx = i;
        scan_word = w;
    endtask
    // released word flips so stale data never looks valid
    task idle;
        @(posedge clk_sys);
        #1;
        {scan_valid, scan_sp_en, scan_stat_slot} = 3'h0;
        scan_word = ~scan_word;
    endtask
endmodule

// ### swd_setpoint_window_detector.v
// Contract
// (R01) each setpoint stores a 16-bit high limit and low limit
// (R02) inside: word below high limit and above low limit
// (R03) outside: word above high limit or below low limit
// (R04) greater-than: word above low limit, high limit ignored
// (R05) less-than: word below high limit, low limit ignored
// (R06) equal-to: word equals high limit, low limit ignored
// (R07) host uses equal-to only for counter or digital sources
// (R08) hysteresis: above high forces value two, below low forces one
// (R09) hysteresis: inside window leaves output and detect unchanged
// (R10) hysteresis always forces updates, update mode ignored
// (R11) hysteresis may target a timer as well as a DAC
// (R12) store true value, select target none, DAC or timer
// (R13) true-and-false mode writes second value when false
// (R14) true-only mode writes only when criterion met
// (R15) shared output holds value of most recently true setpoint; the code keeps the value of the latest to turn true
// (R16) host loads all setpoint setup before arming
// (R17) evaluation starts as soon as acquisition is armed
// (R18) status word: setpoint 0 at bit 0, setpoint 15 at bit 15
// (R19) status bit is 1 while criterion met, else 0
// (R20) host places status word last in scan list
// (R21) at most 16 setpoints, one per scanned channel word
// (R22) detect re-evaluated once per scan period
// (R23) counter lower and upper words take separate setpoints
// (R24) evaluate on stream entry; status and output from same evaluation
`timescale 1ns/10ps
`include "swd_defines.vh"

module swd_setpoint_window_detector #(
    parameter NUM_SP = 16,                    // setpoints in a scan group
    parameter IDX_W  = 4                      // setpoint index width
) (
    input  wire              clk_sys,         // system clock
    input  wire              rstn,            // sync reset, low
    input  wire              cfg_we,          // setup write strobe
    input  wire [IDX_W-1:0]  cfg_idx,         // setpoint addressed
    input  wire [2:0]        cfg_fld,         // field select
    input  wire [15:0]       cfg_wdata,       // setup write data
    input  wire              acq_armed,       // acquisition armed level
    input  wire              scan_valid,      // channel word in stream
    input  wire [15:0]       scan_word,       // channel word
    input  wire              scan_sp_en,      // word carries a setpoint
    input  wire [IDX_W-1:0]  scan_sp_idx,     // its setpoint number
    input  wire              scan_stat_slot,  // status word slot
    output reg  [NUM_SP-1:0] setpoint_state_flags, // live detect flags
    output reg  [NUM_SP-1:0] channel_match_flag,   // per-eval detect mark
    output reg               stat_valid,      // status word in stream
    output reg  [15:0]       stat_word,       // status word data
    output reg  [15:0]       analog_out_zero, // DAC 0 value
    output reg  [15:0]       analog_out_one,  // DAC 1 value
    output reg  [15:0]       pulse_output_zero, // timer 0 value
    output reg  [15:0]       pulse_output_one,  // timer 1 value
    output reg  [3:0]        out_upd_stb      // one-cycle update strobes
);

    // ************************************************************
    // setpoint storage
    // ************************************************************
    // (R01) limit storage
    reg [15:0]            hi_mem    [0:NUM_SP-1];
    reg [15:0]            lo_mem    [0:NUM_SP-1];
    // (R12) update values and mode
    reg [15:0]            vtrue_mem [0:NUM_SP-1];
    reg [15:0]            vfalse_mem[0:NUM_SP-1];
    reg [`SWD_MODE_W-1:0] mode_mem  [0:NUM_SP-1];

    reg [NUM_SP-1:0]      hyst_hi_r;   // hysteresis side latch
    reg [NUM_SP-1:0]      seen_r;      // evaluated since arming
    reg                   armed_d_r;   // arm edge detect
    integer               i;

    // ************************************************************
    // index range guards
    // ************************************************************
    // (R21) indexes past the last setpoint are dropped; a narrow
    // build would otherwise reach outside its tables
    wire                  cfg_idx_ok;
    wire                  scan_idx_ok;

    assign cfg_idx_ok  = (cfg_idx < NUM_SP);
    assign scan_idx_ok = (scan_sp_idx < NUM_SP);

    // ************************************************************
    // status word assembly
    // ************************************************************
    reg [15:0]            stat_nxt;
    integer               b;

    // (R18) setpoint n sits at bit n, missing setpoints read zero
    always @* begin
        stat_nxt = 16'h0000;
        for (b = 0; b < 16; b = b + 1) begin
            if (b < NUM_SP) begin
                stat_nxt[b] = setpoint_state_flags[b];
            end
        end
    end

    // ************************************************************
    // criterion evaluation
    // ************************************************************
    // one comparator set shared by all setpoints, the stream is serial
    function crit_met;
        input [15:0] w;
        input [15:0] hi;
        input [15:0] lo;
        input [2:0]  crit;
        begin
            case (crit)
                // (R02) strict window
                `SWD_CRIT_INSIDE:  crit_met = (w < hi) && (w > lo);
                // (R03) either side out
                `SWD_CRIT_OUTSIDE: crit_met = (w > hi) || (w < lo);
                // (R04) low limit only
                `SWD_CRIT_GREATER: crit_met = (w > lo);
                // (R05) high limit only
                `SWD_CRIT_LESS:    crit_met = (w < hi);
                // (R06) exact match on high limit
                `SWD_CRIT_EQUAL:   crit_met = (w == hi);
                default:           crit_met = 1'b0;
            endcase
        end
    endfunction

    // ************************************************************
    // output target decode
    // ************************************************************
    // target code to strobe bit; codes past the last timer give no
    // strobe, so a bad target code can never write an output
    function [3:0] tgt_stb;
        input [2:0] tgt;
        begin
            if (tgt == `SWD_TGT_ANALOG_OUT_ZERO) begin
                tgt_stb = 4'h1;
            end else if (tgt == `SWD_TGT_ANALOG_OUT_ONE) begin
                tgt_stb = 4'h2;
            end else if (tgt == `SWD_TGT_TMR0) begin
                tgt_stb = 4'h4;
            end else if (tgt == `SWD_TGT_TMR1) begin
                tgt_stb = 4'h8;
            end else begin
                tgt_stb = 4'h0;
            end
        end
    endfunction

    // ************************************************************
    // evaluation decision
    // ************************************************************
    reg [15:0]            cur_hi;
    reg [15:0]            cur_lo;
    reg [`SWD_MODE_W-1:0] cur_mode;
    reg [2:0]             cur_crit;
    reg [2:0]             cur_tgt;
    reg                   eval_en;
    reg                   first_eval;
    reg                   met;
    reg                   flag_nxt;
    reg                   hyst_nxt;
    reg                   wr_en;
    reg [15:0]            wr_val;

    // decide new detect state and output write for this word
    always @* begin
        cur_hi   = hi_mem[scan_sp_idx];
        cur_lo   = lo_mem[scan_sp_idx];
        cur_mode = mode_mem[scan_sp_idx];
        cur_crit = cur_mode[`SWD_MODE_CRIT_MSB:`SWD_MODE_CRIT_LSB];
        cur_tgt  = cur_mode[`SWD_MODE_TGT_MSB:`SWD_MODE_TGT_LSB];
        // (R17) armed alone opens evaluation
        // (R21) one setpoint per stream word
        // (R23) each counter half comes with its own index
        eval_en  = acq_armed && scan_valid && scan_sp_en && scan_idx_ok;
        // a re-arm makes every setpoint act once more on its first word
        first_eval = !seen_r[scan_sp_idx] || (acq_armed && !armed_d_r);
        met      = crit_met(scan_word, cur_hi, cur_lo, cur_crit);
        flag_nxt = setpoint_state_flags[scan_sp_idx];
        hyst_nxt = hyst_hi_r[scan_sp_idx];
        wr_en    = 1'b0;
        wr_val   = vtrue_mem[scan_sp_idx];
        if (cur_crit == `SWD_CRIT_HYST) begin
            // (R10) forced update, mode bit not consulted
            // (R08) above high forces value two
            if (scan_word > cur_hi) begin
                hyst_nxt = 1'b1;
                flag_nxt = 1'b1;
                wr_en    = !hyst_hi_r[scan_sp_idx] ||
                           first_eval;
                wr_val   = vfalse_mem[scan_sp_idx];
            end else if (scan_word < cur_lo) begin
                // (R08) below low forces value one
                hyst_nxt = 1'b0;
                flag_nxt = 1'b0;
                wr_en    = hyst_hi_r[scan_sp_idx] ||
                           first_eval;
                wr_val   = vtrue_mem[scan_sp_idx];
            end
            // (R09) inside window: nothing changes
        end else begin
            // (R19) detect follows the criterion
            flag_nxt = met;
            // (R15) write only on a change or a first evaluation, so the latest setpoint to turn true wins
            if (first_eval ||
                met != setpoint_state_flags[scan_sp_idx]) begin
                if (met) begin
                    // (R14) write on true
                    wr_en  = 1'b1;
                    wr_val = vtrue_mem[scan_sp_idx];
                end else if (cur_mode[`SWD_MODE_TF_BIT]) begin
                    // (R13) false value in true-and-false mode
                    wr_en  = 1'b1;
                    wr_val = vfalse_mem[scan_sp_idx];
                end
            end
        end
        if (!eval_en || tgt_stb(cur_tgt) == 4'h0) begin
            wr_en = 1'b0;
        end
        if (!eval_en) begin
            flag_nxt = setpoint_state_flags[scan_sp_idx];
            hyst_nxt = hyst_hi_r[scan_sp_idx];
        end
    end

    // ************************************************************
    // setup writes
    // ************************************************************
    // no reset on storage; the host loads it before arming
    always @(posedge clk_sys) begin
        if (cfg_we && cfg_idx_ok) begin
            if (cfg_fld == `SWD_FLD_HIGH) begin
                hi_mem[cfg_idx] <= cfg_wdata;
            end else if (cfg_fld == `SWD_FLD_LOW) begin
                lo_mem[cfg_idx] <= cfg_wdata;
            end else if (cfg_fld == `SWD_FLD_MODE) begin
                mode_mem[cfg_idx] <= cfg_wdata[`SWD_MODE_W-1:0];
            end else if (cfg_fld == `SWD_FLD_VAL_TRUE) begin
                vtrue_mem[cfg_idx] <= cfg_wdata;
            end else if (cfg_fld == `SWD_FLD_VAL_FALSE) begin
                vfalse_mem[cfg_idx] <= cfg_wdata;
            end
        end
    end

    // ************************************************************
    // detect state, status word and outputs
    // ************************************************************
    // (R24) status bit and output move on the same evaluation
    always @(posedge clk_sys) begin
        if (!rstn) begin
            setpoint_state_flags <= {NUM_SP{1'b0}};
            channel_match_flag   <= {NUM_SP{1'b0}};
            hyst_hi_r            <= {NUM_SP{1'b0}};
            seen_r               <= {NUM_SP{1'b0}};
            armed_d_r            <= 1'b0;
            stat_valid           <= 1'b0;
            stat_word            <= `SWD_RST_WORD;
            analog_out_zero      <= `SWD_RST_WORD;
            analog_out_one       <= `SWD_RST_WORD;
            pulse_output_zero    <= `SWD_RST_WORD;
            pulse_output_one     <= `SWD_RST_WORD;
            out_upd_stb          <= 4'h0;
        end else begin
            armed_d_r   <= acq_armed;
            out_upd_stb <= 4'h0;
            // fresh arm: first evaluation of each setpoint counts as a change
            if (acq_armed && !armed_d_r) begin
                seen_r <= {NUM_SP{1'b0}};
            end
            // a word judged on the arming edge counts as seen; this
            // later assignment wins over the clear above
            if (eval_en) begin
                seen_r[scan_sp_idx] <= 1'b1;
            end
            // (R22) each flag moves only when its word comes by
            if (eval_en) begin
                setpoint_state_flags[scan_sp_idx] <= flag_nxt;
                hyst_hi_r[scan_sp_idx]            <= hyst_nxt;
                for (i = 0; i < NUM_SP; i = i + 1) begin
                    channel_match_flag[i] <= (i == scan_sp_idx) ?
                        flag_nxt : setpoint_state_flags[i];
                end
            end
            // (R11) timer targets share the forced path
            if (wr_en) begin
                out_upd_stb <= tgt_stb(cur_tgt);
                if (cur_tgt == `SWD_TGT_ANALOG_OUT_ZERO) begin
                    analog_out_zero <= wr_val;
                end else if (cur_tgt == `SWD_TGT_ANALOG_OUT_ONE) begin
                    analog_out_one  <= wr_val;
                end else if (cur_tgt == `SWD_TGT_TMR0) begin
                    pulse_output_zero <= wr_val;
                end else if (cur_tgt == `SWD_TGT_TMR1) begin
                    pulse_output_one <= wr_val;
                end
            end
            // (R18) status slot shows flags from before this judgement
            stat_valid <= scan_valid && scan_stat_slot;
            if (scan_valid && scan_stat_slot) begin
                stat_word <= stat_nxt;
            end
        end
    end

endmodule

// ### tb_top.sv
`timescale 1ns/10ps
`include "swd_defines.vh"
module tb_top;
    reg         clk_sys, rstn, cfg_we, acq_armed;
    reg  [3:0]  cfg_idx;
    reg  [2:0]  cfg_fld;
    reg  [15:0] cfg_wdata, ef;
    wire        scan_valid, scan_sp_en, scan_stat_slot, stat_valid;
    wire [3:0]  scan_sp_idx, out_upd_stb;
    wire [15:0] scan_word, setpoint_state_flags, channel_match_flag, stat_word;
    wire [15:0] analog_out_zero, analog_out_one;
    wire [15:0] pulse_output_zero, pulse_output_one;
    integer     num_errors, cmp_count, k, j;
    swd_scan_seq SEQ (.clk_sys(clk_sys), .scan_valid(scan_valid),
        .scan_word(scan_word), .scan_sp_en(scan_sp_en),
        .scan_sp_idx(scan_sp_idx), .scan_stat_slot(scan_stat_slot));
    swd_setpoint_window_detector DUT (.clk_sys(clk_sys), .rstn(rstn),
        .cfg_we(cfg_we), .cfg_idx(cfg_idx), .cfg_fld(cfg_fld),
        .cfg_wdata(cfg_wdata), .acq_armed(acq_armed), .scan_valid(scan_valid),
        .scan_word(scan_word), .scan_sp_en(scan_sp_en),
        .scan_sp_idx(scan_sp_idx), .scan_stat_slot(scan_stat_slot),
        .setpoint_state_flags(setpoint_state_flags),
        .channel_match_flag(channel_match_flag), .stat_valid(stat_valid),
        .stat_word(stat_word), .analog_out_zero(analog_out_zero),
        .analog_out_one(analog_out_one), .pulse_output_zero(pulse_output_zero),
        .pulse_output_one(pulse_output_one), .out_upd_stb(out_upd_stb));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task chk(input [15:0] seen, input [15:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task cfg(input [3:0] i, input [2:0] f, input [15:0] d);
        @(posedge clk_sys);
        #1;
        {cfg_we, cfg_idx, cfg_fld, cfg_wdata} = {1'b1, i, f, d};
    endtask
    task sp(input [3:0] i, input [15:0] hi, lo, input [2:0] cr, tg,
            input tf, input [15:0] vt, vf);
        cfg(i, `SWD_FLD_HIGH, hi);
        cfg(i, `SWD_FLD_LOW, lo);
        cfg(i, `SWD_FLD_MODE, {9'h000, tf, tg, cr});
        cfg(i, `SWD_FLD_VAL_TRUE, vt);
        cfg(i, `SWD_FLD_VAL_FALSE, vf);
    endtask
    // evaluation seen one cycle after the word, strobe still up
    task ev(input [3:0] i, input [15:0] w);
        SEQ.put(1'b1, i, w, 1'b0);
        SEQ.idle;
    endtask
    task eo(input [3:0] i, input [15:0] w, input [1:0] o, input [15:0] e);
        ev(i, w);
        case (o)
            2'h0: chk(analog_out_zero, e);
            2'h1: chk(analog_out_one, e);
            2'h2: chk(pulse_output_zero, e);
            default: chk(pulse_output_one, e);
        endcase
    endtask
    function det(input [2:0] c, input [15:0] w);
        case (c)
            `SWD_CRIT_INSIDE:  det = (w < 16'h8000) && (w > 16'h4000);
            `SWD_CRIT_OUTSIDE: det = (w > 16'h8000) || (w < 16'h4000);
            `SWD_CRIT_GREATER: det = w > 16'h4000;
            `SWD_CRIT_LESS:    det = w < 16'h8000;
            default:           det = w == 16'h8000;
        endcase
    endfunction
    // hang guard, far beyond the some 180 cycles the tests need
    initial begin
        #200000;
        num_errors = num_errors + 1;
        stop_test;
    end
    initial begin
        {num_errors, cmp_count, ef} = 0;
        {rstn, cfg_we, cfg_idx, cfg_fld, cfg_wdata, acq_armed} = 0;
        repeat (12) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        chk(setpoint_state_flags | stat_word | analog_out_zero, 16'h0000);
        $display("reset test done");
        for (k = 0; k < 5; k = k + 1)
            sp(k[3:0], 16'h8000, 16'h4000, k[2:0], `SWD_TGT_NONE, 0, 0, 0);
        // equal-to on the two words of one counter
        sp(10, 16'h0003, 0, `SWD_CRIT_EQUAL, `SWD_TGT_NONE, 0, 0, 0);
        sp(11, 16'h0001, 0, `SWD_CRIT_EQUAL, `SWD_TGT_NONE, 0, 0, 0);
        sp(5, 16'h1000, 0, `SWD_CRIT_LESS, `SWD_TGT_ANALOG_OUT_ZERO, 1, 16'hAAAA, 16'h5555);
        sp(6, 16'h1000, 0, `SWD_CRIT_LESS, `SWD_TGT_TMR0, 0, 16'h1111, 16'h2222);
        sp(7, 16'h0100, 16'h0010, 0, `SWD_TGT_ANALOG_OUT_ONE, 0, 16'h0700, 0);
        sp(8, 16'h0100, 16'h0010, 0, `SWD_TGT_ANALOG_OUT_ONE, 0, 16'h0800, 0);
        sp(9, 16'h8000, 16'h4000, `SWD_CRIT_HYST, `SWD_TGT_TMR1, 0, 1, 2);
        sp(15, 0, 0, `SWD_CRIT_GREATER, `SWD_TGT_NONE, 0, 0, 0);
        cfg(0, 3'h7, 16'hFFFF);
        @(posedge clk_sys);
        #1;
        cfg_we = 1'b0;
        ev(0, 16'h6000);
        chk(setpoint_state_flags, 16'h0000);
        SEQ.put(1'b1, 15, 16'h0001, 1'b0);
        acq_armed = 1'b1;
        SEQ.idle;
        ef[15] = 1'b1;
        chk(setpoint_state_flags, ef);
        for (k = 0; k < 5; k = k + 1)
            for (j = 0; j < 6; j = j + 1) begin
                ev(k[3:0], {16'h3FFF, 16'h4000, 16'h4001, 16'h7FFF, 16'h8000,
                    16'h8001} >> (j * 16));
                ef[k] = det(k[2:0], {16'h3FFF, 16'h4000, 16'h4001, 16'h7FFF,
                    16'h8000, 16'h8001} >> (j * 16));
                chk(setpoint_state_flags, ef);
                chk(channel_match_flag, ef);
                chk({12'h000, out_upd_stb}, 16'h0000);
            end
        $display("criteria test done");
        eo(5, 16'h0800, 0, 16'hAAAA);
        chk({12'h000, out_upd_stb}, 16'h0001);
        eo(5, 16'h2000, 0, 16'h5555);
        eo(6, 16'h2000, 2, 16'h0000);
        eo(6, 16'h0800, 2, 16'h1111);
        eo(6, 16'h2000, 2, 16'h1111);
        eo(7, 16'h0050, 1, 16'h0700);
        eo(8, 16'h0050, 1, 16'h0800);
        eo(7, 16'h0050, 1, 16'h0800);
        eo(9, 16'h9000, 3, 16'h0002);
        chk({12'h000, out_upd_stb}, 16'h0008);
        eo(9, 16'h6000, 3, 16'h0002);
        eo(9, 16'h3000, 3, 16'h0001);
        eo(9, 16'h6000, 3, 16'h0001);
        chk({15'h0000, setpoint_state_flags[9]}, 16'h0000);
        eo(9, 16'h9000, 3, 16'h0002);
        $display("output test done");
        SEQ.put(1'b1, 10, 16'h0003, 1'b0);
        SEQ.put(1'b1, 11, 16'h0001, 1'b0);
        SEQ.put(1'b0, 0, 16'h0000, 1'b1);
        SEQ.idle;
        ef[11:5] = 7'h7C;
        chk(stat_word, ef);
        chk({15'h0000, stat_valid}, 16'h0001);
        $display("status test done");
        // a re-arm lets a setpoint that stayed true write once more
        ev(6, 16'h0800);
        acq_armed = 1'b0;
        ev(6, 16'h0800);
        chk({12'h000, out_upd_stb}, 16'h0000);
        acq_armed = 1'b1;
        eo(6, 16'h0800, 2, 16'h1111);
        chk({12'h000, out_upd_stb}, 16'h0004);
        $display("rearm test done");
        stop_test;
    end
endmodule
